/* hdl/hub_port_config_bytes.sv */
// hub port configuration bank behind an axi4-lite slave
// assumes strap pins and over-current sense are asynchronous to core_clk
// What this block does
// R1: bits 5:4 of byte two pick over-current delay 50, 100, 200 or 400 ns; 50 ns runs as one 100 ns cycle.
// R2: bit 3 of byte two reports the hub as part of a compound device.
// R3: software declaring compound must mark the matching ports fixed.
// R4: in strap configuration any fixed-port strap reports compound.
// R5: remap enable clear numbers the active ports upward from 1, closing disabled gaps.
// R6: standard mode takes disabled ports from straps or disable bytes.
// R7: remap enable set takes reported numbers from the two remap bytes.
// R8: each fixed-device bit tells the host an active port holds one.
// R9: fixed-device bits 3..1 map ports 3..1; bits 7..4 and 0 reserved.
// R10: in strap configuration the fixed-port straps replace the byte.
// R11: firmware must set fixed-device bit 1 for the internal card reader.
// R12: a fixed device supplies its own descriptors, the hub none.
// R13: reserved bits read as zero and ignore writes.
`timescale 1ns/1ns
module hub_port_config_bytes (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // axi4-lite write address and data
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // strap pins and over-current sense
    input wire logic strap_config_sel,
    input wire logic self_powered_strap,
    input wire logic [1:0] fixed_port_straps,
    input wire logic [1:0] port_disable_straps,
    input wire logic overcurrent_sense,
    // configuration seen by the hub core
    output logic [1:0] overcurrent_delay_sel,
    output logic overcurrent_fault,
    output logic compound_device,
    output logic explicit_port_remap_mode,
    output logic [3:0] reported_num_p1,
    output logic [3:0] reported_num_p2,
    output logic [3:0] reported_num_p3,
    output logic [2:0] active_ports,
    output logic [1:0] active_port_count,
    output logic [7:0] fixed_device_port_mask,
    output logic [2:0] hub_descriptor_ports
);
    // decode a byte address into a register select; unaligned never hits
    function automatic logic [3:0] reg_sel(input logic [15:0] a);
        logic [15:0] i;
        i = (a[1:0] == 2'b00) ? {2'b00, a[15:2]} : 16'hffff;
        if (i == hub_cfg_pkg::IDX_CFG_TWO) begin
            return hub_cfg_pkg::SEL_CFG_TWO;
        end else if (i == hub_cfg_pkg::IDX_CFG_THREE) begin
            return hub_cfg_pkg::SEL_CFG_THREE;
        end else if (i == hub_cfg_pkg::IDX_FIXED_PORTS) begin
            return hub_cfg_pkg::SEL_FIXED_PORTS;
        end else if (i == hub_cfg_pkg::IDX_DIS_SELF) begin
            return hub_cfg_pkg::SEL_DIS_SELF;
        end else if (i == hub_cfg_pkg::IDX_DIS_BUS) begin
            return hub_cfg_pkg::SEL_DIS_BUS;
        end else if (i == hub_cfg_pkg::IDX_REMAP_LO) begin
            return hub_cfg_pkg::SEL_REMAP_LO;
        end else if (i == hub_cfg_pkg::IDX_REMAP_HI) begin
            return hub_cfg_pkg::SEL_REMAP_HI;
        end else if (i == hub_cfg_pkg::IDX_STATUS) begin
            return hub_cfg_pkg::SEL_STATUS;
        end else begin
            return hub_cfg_pkg::SEL_NONE;
        end
    endfunction
    // writable bits of each storage slot
    function automatic logic [7:0] wmask(input logic [3:0] sel);
        case (sel)
            hub_cfg_pkg::SEL_CFG_TWO: return hub_cfg_pkg::MASK_CFG_TWO;
            hub_cfg_pkg::SEL_CFG_THREE: return hub_cfg_pkg::MASK_CFG_THREE;
            hub_cfg_pkg::SEL_REMAP_LO: return hub_cfg_pkg::MASK_REMAP_LO;
            hub_cfg_pkg::SEL_REMAP_HI: return hub_cfg_pkg::MASK_REMAP_HI;
            default: return hub_cfg_pkg::MASK_PORTS;
        endcase
    endfunction
    logic [7:0] regs_r [0:6];
    logic [6:0] pin_meta_r, pin_sync_r;
    logic [1:0] start_cnt_r, fixed_strap_r, dis_strap_r;
    logic captured_r, strap_mode_r, self_pwr_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_held_r, w_held_r, wstrb_r;
    logic [15:0] awaddr_r;
    logic [7:0] wdata_r, rdata_r, fixed_mask_r;
    logic [1:0] bresp_r, rresp_r, oc_sel_r, count_r;
    logic [3:0] oc_cnt_r, num1_r, num2_r, num3_r;
    logic oc_fault_r, compound_r, remap_r;
    logic [2:0] active_r, desc_r;
    // strap and sense pins cross into core_clk through two flops
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_r <= 7'h00;
            pin_sync_r <= 7'h00;
        end else begin
            pin_meta_r <= {overcurrent_sense, strap_config_sel,
                           self_powered_strap, fixed_port_straps,
                           port_disable_straps};
            pin_sync_r <= pin_meta_r;
        end
    end
    // straps are caught once, after the synchroniser has filled
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_cnt_r <= 2'h0;
            captured_r <= 1'b0;
            strap_mode_r <= 1'b0;
            self_pwr_r <= 1'b0;
            fixed_strap_r <= 2'h0;
            dis_strap_r <= 2'h0;
        end else if (!captured_r) begin
            start_cnt_r <= start_cnt_r + 2'h1;
            if (start_cnt_r == hub_cfg_pkg::STARTUP_CYC) begin
                captured_r <= 1'b1;
                strap_mode_r <= pin_sync_r[5];
                self_pwr_r <= pin_sync_r[4];
                fixed_strap_r <= pin_sync_r[3:2];
                dis_strap_r <= pin_sync_r[1:0];
            end
        end
    end
    // bus handshake terms
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire ar_take = s_axi_arvalid && arready_r;
    wire do_wr = aw_held_r && w_held_r && !bvalid_r;
    wire aw_held_nxt = (aw_held_r || aw_take) && !do_wr;
    wire w_held_nxt = (w_held_r || w_take) && !do_wr;
    wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);
    wire rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
    wire [3:0] wr_sel = reg_sel(awaddr_r);
    wire [3:0] rd_sel = reg_sel(s_axi_araddr);
    wire wr_store = do_wr && wstrb_r && (wr_sel < hub_cfg_pkg::N_REGS);
    // status byte shows the hub's live configuration
    wire [7:0] status = {strap_mode_r, remap_r, compound_r, count_r, active_r};
    wire [7:0] rd_byte = (rd_sel < hub_cfg_pkg::N_REGS) ? regs_r[rd_sel[2:0]]
                       : (rd_sel == hub_cfg_pkg::SEL_STATUS) ? status : 8'h00;
    // write channels; address and data may come in either order
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 16'h0000;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= hub_cfg_pkg::RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awready_r <= !aw_held_nxt && !bvalid_nxt;
            wready_r <= !w_held_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb_r <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                bresp_r <= (wr_sel == hub_cfg_pkg::SEL_NONE)
                         ? hub_cfg_pkg::RESP_SLVERR : hub_cfg_pkg::RESP_OKAY;
            end
        end
    end
    // R13: reserved bits dropped; lane 0 only, status ignores writes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 7; i++) begin
                regs_r[i] <= hub_cfg_pkg::REG_RST;
            end
        end else if (wr_store) begin
            regs_r[wr_sel[2:0]] <= wdata_r & wmask(wr_sel);
        end
    end
    // read channel answers one cycle after the address is taken
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= hub_cfg_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_byte;
                rresp_r <= (rd_sel == hub_cfg_pkg::SEL_NONE)
                         ? hub_cfg_pkg::RESP_SLVERR : hub_cfg_pkg::RESP_OKAY;
            end
        end
    end
    // R6: disable source, straps or the power mode's byte
    wire [7:0] dis_reg = self_pwr_r ? regs_r[hub_cfg_pkg::SEL_DIS_SELF[2:0]]
                                    : regs_r[hub_cfg_pkg::SEL_DIS_BUS[2:0]];
    wire [2:0] port_off = strap_mode_r ? {1'b0, dis_strap_r} : dis_reg[3:1];
    // R5: remap gate; straps always run standard numbering
    wire remap_eff = !strap_mode_r &&
        regs_r[hub_cfg_pkg::SEL_CFG_THREE[2:0]][hub_cfg_pkg::REMAP_EN_BIT];
    // R10: strap fixed ports
    wire [2:0] fixed_phys = strap_mode_r ? {1'b0, fixed_strap_r}
                          : regs_r[hub_cfg_pkg::SEL_FIXED_PORTS[2:0]][3:1];
    // R2 R4: compound from byte two, or implied by straps
    wire compound_nxt = strap_mode_r ? |fixed_strap_r
        : regs_r[hub_cfg_pkg::SEL_CFG_TWO[2:0]][hub_cfg_pkg::COMPOUND_BIT];
    wire [1:0] oc_sel = regs_r[hub_cfg_pkg::SEL_CFG_TWO[2:0]]
                        [hub_cfg_pkg::OC_SEL_LSB +: 2];
    wire [3:0] map_num1, map_num2, map_num3;
    wire [2:0] map_active;
    wire [1:0] map_count;
    // R7: remap numbering
    port_number_map u_map (
        .remap_en(remap_eff), .port_off(port_off),
        .remap_lo(regs_r[hub_cfg_pkg::SEL_REMAP_LO[2:0]]),
        .remap_hi(regs_r[hub_cfg_pkg::SEL_REMAP_HI[2:0]]),
        .num_p1(map_num1), .num_p2(map_num2), .num_p3(map_num3),
        .active(map_active), .count(map_count)
    );
    // R1: delay select; sub-period delays still cost a whole cycle
    wire [3:0] oc_lim = (oc_sel == 2'h0) ? hub_cfg_pkg::OC_C0
                      : (oc_sel == 2'h1) ? hub_cfg_pkg::OC_C1
                      : (oc_sel == 2'h2) ? hub_cfg_pkg::OC_C2
                      : hub_cfg_pkg::OC_C3;
    wire oc_in = pin_sync_r[6];
    wire [3:0] oc_cnt_nxt = !oc_in ? 4'h0
                          : (oc_cnt_r >= oc_lim) ? oc_cnt_r : oc_cnt_r + 4'h1;
    // R8 R9 R12: fixed mask in bits 3..1, hub describes the rest
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_cnt_r <= 4'h0;
            oc_fault_r <= 1'b0;
            oc_sel_r <= 2'h0;
            compound_r <= 1'b0;
            remap_r <= 1'b0;
            num1_r <= 4'h0;
            num2_r <= 4'h0;
            num3_r <= 4'h0;
            active_r <= 3'h0;
            count_r <= 2'h0;
            fixed_mask_r <= 8'h00;
            desc_r <= 3'h0;
        end else begin
            oc_cnt_r <= oc_cnt_nxt;
            oc_fault_r <= oc_in && (oc_cnt_nxt >= oc_lim);
            oc_sel_r <= oc_sel;
            compound_r <= compound_nxt;
            remap_r <= remap_eff;
            num1_r <= map_num1;
            num2_r <= map_num2;
            num3_r <= map_num3;
            active_r <= map_active;
            count_r <= map_count;
            fixed_mask_r <= {4'h0, fixed_phys & map_active, 1'b0};
            desc_r <= map_active & ~fixed_phys;
        end
    end
    // outputs come straight from the flops above
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = {24'h000000, rdata_r};
    assign overcurrent_delay_sel = oc_sel_r;
    assign overcurrent_fault = oc_fault_r;
    assign compound_device = compound_r;
    assign explicit_port_remap_mode = remap_r;
    assign reported_num_p1 = num1_r;
    assign reported_num_p2 = num2_r;
    assign reported_num_p3 = num3_r;
    assign active_ports = active_r;
    assign active_port_count = count_r;
    assign fixed_device_port_mask = fixed_mask_r;
    assign hub_descriptor_ports = desc_r;
    // checks on the configuration the hub core sees
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_oc_sel;
        overcurrent_delay_sel == $past(oc_sel);
    endproperty
    a_oc_sel: assert property (p_oc_sel) // R1
        else $error("delay select stale");
    property p_oc_wait;
        $rose(overcurrent_fault) && oc_lim == 4'h4
            |-> $past(oc_in, 1) && $past(oc_in, 2) && $past(oc_in, 4);
    endproperty
    a_oc_wait: assert property (p_oc_wait) // R1
        else $error("fault too early");
    property p_compound_reg;
        !strap_mode_r |=> compound_device == $past(compound_nxt);
    endproperty
    a_compound_reg: assert property (p_compound_reg) // R2
        else $error("compound not from byte two");
    property p_compound_strap;
        strap_mode_r && fixed_strap_r != 2'h0 |=> compound_device;
    endproperty
    a_compound_strap: assert property (p_compound_strap) // R4
        else $error("strap compound missing");
    property p_std_gap;
        !remap_eff && port_off == 3'h1 |=> reported_num_p1 == 4'h0
            && reported_num_p2 == 4'h1 && reported_num_p3 == 4'h2;
    endproperty
    a_std_gap: assert property (p_std_gap) // R5
        else $error("numbering not contiguous");
    property p_dis_self;
        !strap_mode_r && self_pwr_r && !remap_eff && dis_reg[1]
            |=> !active_ports[0];
    endproperty
    a_dis_self: assert property (p_dis_self) // R6
        else $error("self disable ignored");
    property p_remap;
        remap_eff |=> reported_num_p3 ==
            $past(regs_r[hub_cfg_pkg::SEL_REMAP_HI[2:0]][3:0]);
    endproperty
    a_remap: assert property (p_remap) // R7
        else $error("port three not remapped");
    property p_fixed_active;
        (fixed_device_port_mask[3:1] & ~active_ports) == 3'h0
            && fixed_device_port_mask[0] == 1'b0
            && fixed_device_port_mask[7:4] == 4'h0;
    endproperty
    a_fixed_active: assert property (p_fixed_active) // R9
        else $error("fixed mask out of range");
    property p_fixed_strap;
        strap_mode_r ##1 strap_mode_r
            |-> fixed_device_port_mask[2:1] == ($past(fixed_strap_r)
                & $past(map_active[1:0]));
    endproperty
    a_fixed_strap: assert property (p_fixed_strap) // R10
        else $error("fixed mask not from straps");
    property p_desc;
        (hub_descriptor_ports & fixed_device_port_mask[3:1]) == 3'h0;
    endproperty
    a_desc: assert property (p_desc) // R12
        else $error("fixed port described");
    property p_reserved;
        (regs_r[hub_cfg_pkg::SEL_CFG_TWO[2:0]] & ~hub_cfg_pkg::MASK_CFG_TWO)
            == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) // R13
        else $error("reserved bits stored");

endmodule

/* hdl/hub_cfg_pkg.sv */
// constants shared by the hub port configuration bank and its test bench
// assumes a 10 MHz core clock and an axi4-lite register bus
package hub_cfg_pkg;

    // register indices; the byte address is four times the index
    localparam logic [15:0] IDX_CFG_TWO = 16'h00e5;
    localparam logic [15:0] IDX_CFG_THREE = 16'h00e6;
    localparam logic [15:0] IDX_FIXED_PORTS = 16'h00e7;
    localparam logic [15:0] IDX_DIS_SELF = 16'h300a;
    localparam logic [15:0] IDX_DIS_BUS = 16'h300b;
    localparam logic [15:0] IDX_REMAP_LO = 16'h30fb;
    localparam logic [15:0] IDX_REMAP_HI = 16'h30fc;
    localparam logic [15:0] IDX_STATUS = 16'h0010;

    // register selects after decode; storage slots come first
    localparam logic [3:0] SEL_CFG_TWO = 4'h0;
    localparam logic [3:0] SEL_CFG_THREE = 4'h1;
    localparam logic [3:0] SEL_FIXED_PORTS = 4'h2;
    localparam logic [3:0] SEL_DIS_SELF = 4'h3;
    localparam logic [3:0] SEL_DIS_BUS = 4'h4;
    localparam logic [3:0] SEL_REMAP_LO = 4'h5;
    localparam logic [3:0] SEL_REMAP_HI = 4'h6;
    localparam logic [3:0] SEL_STATUS = 4'h7;
    localparam logic [3:0] SEL_NONE = 4'hf;
    localparam logic [3:0] N_REGS = 4'h7;

    // reset value and writable bits of each byte
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MASK_CFG_TWO = 8'h38;
    localparam logic [7:0] MASK_CFG_THREE = 8'h08;
    localparam logic [7:0] MASK_PORTS = 8'h0e;
    localparam logic [7:0] MASK_REMAP_LO = 8'hff;
    localparam logic [7:0] MASK_REMAP_HI = 8'h0f;

    // field positions
    localparam int OC_SEL_LSB = 4;
    localparam int COMPOUND_BIT = 3;
    localparam int REMAP_EN_BIT = 3;

    // over-current delay choices; least times round up to whole cycles
    localparam int T_CLK_NS = 100;
    localparam int OC_T0_NS = 50;
    localparam int OC_T1_NS = 100;
    localparam int OC_T2_NS = 200;
    localparam int OC_T3_NS = 400;
    localparam logic [3:0] OC_C0 = 4'((OC_T0_NS + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] OC_C1 = 4'((OC_T1_NS + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] OC_C2 = 4'((OC_T2_NS + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] OC_C3 = 4'((OC_T3_NS + T_CLK_NS - 1) / T_CLK_NS);

    // cycles after reset release before straps are caught
    localparam logic [1:0] STARTUP_CYC = 2'h3;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // byte address of a register index
    function automatic logic [15:0] byte_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

endpackage

/* hdl/port_number_map.sv */
// works out the port number the host sees for each physical port
// assumes settled mode and disable inputs from the same clock domain
`timescale 1ns/1ns
module port_number_map (
    // mode and port selection
    input wire logic remap_en,
    input wire logic [2:0] port_off,
    input wire logic [7:0] remap_lo,
    input wire logic [7:0] remap_hi,
    // reported numbers, zero for a port the host does not see
    output logic [3:0] num_p1,
    output logic [3:0] num_p2,
    output logic [3:0] num_p3,
    output logic [2:0] active,
    output logic [1:0] count
);

    logic [3:0] std1;
    logic [3:0] std2;
    logic [3:0] std3;

    // standard mode: close the gaps left by disabled ports
    assign std1 = port_off[0] ? 4'h0 : 4'h1;
    assign std2 = port_off[1] ? 4'h0 : 4'h1 + {3'h0, !port_off[0]};
    assign std3 = port_off[2] ? 4'h0
                : 4'h1 + {3'h0, !port_off[0]} + {3'h0, !port_off[1]};

    // remap mode: each nibble names the number, zero hides the port
    assign num_p1 = remap_en ? remap_lo[3:0] : std1;
    assign num_p2 = remap_en ? remap_lo[7:4] : std2;
    assign num_p3 = remap_en ? remap_hi[3:0] : std3;

    // active ports and how many the host sees
    assign active = {|num_p3, |num_p2, |num_p1};
    assign count = {1'b0, active[0]} + {1'b0, active[1]} + {1'b0, active[2]};

endmodule

/* sim/strap_pin_model.sv */
// strap pins and over-current sense wired to the hub configuration bank
// assumes the bench requests levels; straps only move while reset is held
`timescale 1ns/1ns
module strap_pin_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // requested levels {sel, self, fixed[1:0], disable[1:0], sense}
    input wire logic [6:0] want,
    // pins
    output logic strap_config_sel,
    output logic self_powered_strap,
    output logic [1:0] fixed_port_straps,
    output logic [1:0] port_disable_straps,
    output logic overcurrent_sense
);
    // straps are fitted once, so they follow a request only under reset
    initial {strap_config_sel, self_powered_strap} = 2'h0;
    initial {fixed_port_straps, port_disable_straps, overcurrent_sense} = 5'h0;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            {strap_config_sel, self_powered_strap} <= want[6:5];
            {fixed_port_straps, port_disable_straps} <= want[4:1];
        end
        overcurrent_sense <= want[0];
    end
endmodule

/* sim/hub_port_config_bytes_test.sv */
// self-checking bench for the hub port configuration bank
// assumes the design's axi timing and strap capture
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module hub_port_config_bytes_test;
    // bench signals; strap pins come from the partner model
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, p1, p2, p3;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic fault, cmp, remap;
    logic [1:0] bresp, rresp, dsel, cnt, f2;
    logic [2:0] act, desc;
    logic [7:0] fxm, mdl [7], msk [7];
    logic [6:0] want = 7'h0;
    logic [15:0] idx [7];
    int n_errors = 0, tests_run = 0, t;
    wire logic cfg_sel, self_pw, oc;
    wire logic [1:0] fx_pins, ds_pins;

    always #50 core_clk = ~core_clk;

    strap_pin_model pins_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .want(want), .strap_config_sel(cfg_sel), .self_powered_strap(self_pw),
        .fixed_port_straps(fx_pins), .port_disable_straps(ds_pins),
        .overcurrent_sense(oc));
    hub_port_config_bytes dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .strap_config_sel(cfg_sel),
        .self_powered_strap(self_pw), .fixed_port_straps(fx_pins),
        .port_disable_straps(ds_pins), .overcurrent_sense(oc),
        .overcurrent_delay_sel(dsel), .overcurrent_fault(fault),
        .compound_device(cmp), .explicit_port_remap_mode(remap),
        .reported_num_p1(p1), .reported_num_p2(p2), .reported_num_p3(p3),
        .active_ports(act), .active_port_count(cnt),
        .fixed_device_port_mask(fxm), .hub_descriptor_ports(desc));

    // one write; bready is up from the start
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge core_clk);
        awaddr <= {a[13:0], 2'b00};
        wdata <= {24'h0, d};
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge core_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            if (tb) `CHK("bresp", er, bresp)
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (!tb);
    endtask

    // one read, checked against byte and response
    task automatic rd(input logic [15:0] a, input logic [7:0] e,
        input logic [1:0] er);
        logic ta, tr;
        @(posedge core_clk);
        araddr <= {a[13:0], 2'b00};
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge core_clk);
            ta = arvalid & arready;
            tr = rvalid;
            if (tr) `CHK("rdata", {24'h0, e}, rdata)
            if (tr) `CHK("rresp", er, rresp)
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask

    // write through the model; a clear strobe bit 0 stores nothing
    task automatic wr_m(input int i, input logic [7:0] d, input logic [3:0] s);
        wr(idx[i], d, s, 2'h0);
        if (s[0]) mdl[i] = d & msk[i];
    endtask

    // compare registers and outputs except fault with the model; status, active, count, mask and descriptors only without remap
    task automatic check_all();
        logic [2:0] a, f;
        logic [3:0] k;
        logic [11:0] n;
        logic [1:0] m;
        logic c, rm;
        a = want[6] ? {1'b1, ~want[2:1]} :
            ~(want[5] ? mdl[3][3:1] : mdl[4][3:1]);
        f = want[6] ? {1'b0, want[4:3]} : mdl[2][3:1];
        c = want[6] ? |want[4:3] : mdl[0][3];
        rm = mdl[1][3] & ~want[6];
        m = {1'b0, a[0]} + a[1] + a[2];
        k = 4'h0;
        n = 12'h0;
        for (int p = 0; p < 3; p++) begin
            k = k + {3'h0, a[p]};
            if (a[p]) n[p*4+:4] = k;
        end
        for (int i = 0; i < 7; i++) rd(idx[i], mdl[i], 2'h0);
        `CHK("delay", mdl[0][5:4], dsel)
        `CHK("compound", c, cmp)
        `CHK("remap mode", rm, remap)
        if (rm) n = {mdl[6][3:0], mdl[5]};
        `CHK("numbers", n, {p3, p2, p1})
        if (!rm) begin
            `CHK("active", a, act)
            `CHK("count", m, cnt)
            `CHK("fixed", {4'h0, f & a, 1'b0}, fxm)
            `CHK("descriptors", a & ~f, desc)
            rd(hub_cfg_pkg::IDX_STATUS, {want[6], 1'b0, c, m, a}, 2'h0);
        end
    endtask

    // random traffic; firmware pairs compound with a fixed card reader port
    task automatic rand_run(input int times);
        int i;
        logic [7:0] d;
        logic [3:0] s;
        repeat (times) begin
            i = $urandom % 7;
            d = 8'($urandom);
            s = 4'($urandom);
            if (!i && d[3] && s[0]) wr_m(2, mdl[2] | 8'h02, 4'hf);
            wr_m(i, d, s);
            check_all();
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // three strap setups: bus powered, self powered, strap configured
    initial begin
        idx = '{hub_cfg_pkg::IDX_CFG_TWO, hub_cfg_pkg::IDX_CFG_THREE,
            hub_cfg_pkg::IDX_FIXED_PORTS, hub_cfg_pkg::IDX_DIS_SELF,
            hub_cfg_pkg::IDX_DIS_BUS, hub_cfg_pkg::IDX_REMAP_LO,
            hub_cfg_pkg::IDX_REMAP_HI};
        msk = '{hub_cfg_pkg::MASK_CFG_TWO, hub_cfg_pkg::MASK_CFG_THREE,
            hub_cfg_pkg::MASK_PORTS, hub_cfg_pkg::MASK_PORTS,
            hub_cfg_pkg::MASK_PORTS, hub_cfg_pkg::MASK_REMAP_LO,
            hub_cfg_pkg::MASK_REMAP_HI};
        void'($urandom(32'h883e));
        for (int k = 0; k < 3; k++) begin
            f2 = 2'($urandom % 3 + 1);
            sys_rst <= 1'b1;
            want <= (k == 0) ? 7'h00 : (k == 1) ? 7'h20 :
                {2'h2, f2, ~f2 & 2'($urandom), 1'b0};
            mdl = '{default: 8'h00};
            repeat (6) @(posedge core_clk);
            sys_rst <= 1'b0;
            repeat (6) @(posedge core_clk);
            check_all();
            rand_run(25);
        end
        wr(16'h0100, 8'hff, 4'hf, hub_cfg_pkg::RESP_SLVERR);
        rd(16'h0100, 8'h00, hub_cfg_pkg::RESP_SLVERR);
        wr(hub_cfg_pkg::IDX_STATUS, 8'hff, 4'hf, 2'h0);
        check_all();
        // fault delay: two sync flops, one pin flop, then the chosen delay
        for (int s = 0; s < 4; s++) begin
            wr_m(0, 8'(s << 4), 4'hf);
            want[0] <= 1'b1;
            t = 0;
            do begin
                @(negedge core_clk);
                t++;
            end while (!fault && t < 20);
            `CHK("fault delay", 4 + ((50 << s) + 99) / 100, t)
            @(posedge core_clk);
            want[0] <= 1'b0;
            repeat (6) @(negedge core_clk);
            `CHK("fault clear", 1'b0, fault)
        end
        tally_and_finish();
    end

    // watchdog, well past the expected run
    initial begin
        #(40000 * 100);
        n_errors++;
        tally_and_finish();
    end
endmodule
